// [hdl/ufm_map.svh]
// register offsets, field positions, command codes and reset values
`ifndef UFM_MAP_SVH
`define UFM_MAP_SVH
`define UFM_OFS_MODE 4'h0
`define UFM_OFS_STATUS 4'h1
`define UFM_OFS_CMD 4'h2
`define UFM_OFS_ISR 4'h5
`define UFM_OFS_CTU 4'h6
`define UFM_OFS_CTL 4'h7
`define UFM_OFS_INPORT 4'hd
`define UFM_OFS_OPSET 4'he
`define UFM_OFS_OPCLR 4'hf
`define UFM_CMD_PTR_ONE 4'h1
`define UFM_CMD_RTS_ON 4'h8
`define UFM_CMD_RTS_OFF 4'h9
`define UFM_CMD_TMO_ON 4'ha
`define UFM_CMD_PTR_ZERO 4'hb
`define UFM_CMD_TMO_OFF 4'hc
`define UFM_EN_ON 2'h1
`define UFM_EN_OFF 2'h2
`define UFM_MR1_RX_RTS 7
`define UFM_MR1_PAR_HI 4
`define UFM_MR1_PAR_LO 3
`define UFM_MR1_TAG 2
`define UFM_MR2_TX_RTS 5
`define UFM_MR2_CTS_EN 4
`define UFM_PAR_MULTIDROP 2'h3
`define UFM_ISR_CTR 3
`define UFM_ISR_RECEIVER_READY_FLAG 1
`define UFM_PTR_RESET 2'h1
`define UFM_PTR_LAST 2'h2
`define UFM_BYTE_RESET 8'h00
`define UFM_WORD_RESET 16'h0000
`endif

// [hdl/ufm_pkg.sv]
// shared types of the flow, multidrop and timeout block
package ufm_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic tag;
    logic framing;
    logic brk;
    logic overrun;
  } ufm_rx_char_type;
  typedef enum logic [1:0] {
    UFM_CT_IDLE = 2'b00,
    UFM_CT_LOAD = 2'b01,
    UFM_CT_RUN = 2'b10
  } ufm_ct_state_type;
endpackage

// [hdl/ufm_top.sv]
// flow control, multidrop reception and receive timeout for one channel
// Operation
// [RQ1] each character pushed into receive queue reloads counter, restarts next counter tick; the code reloads on a push only in timeout mode
// [RQ2] counter ending in timeout mode sets counter-ready flag, status bit 3
// [RQ3] counter-ready drives interrupt only when mask bit 3 set
// [RQ4] character received after timeout clears counter-ready and its interrupt
// [RQ5] timeout-on command clears counter-ready and stops counter until next character
// [RQ6] withdrawn timeout with nothing else pending reads status as zero
// [RQ7] clear-to-send enabled and high stops transmitter after current character
// [RQ8] clear-to-send disabled: pin has no effect on transmitter
// [RQ9] flow control drops request-to-send on start bit while queue full
// [RQ10] mode one bit 7 gives receiver the output pin as request-to-send
// [RQ11] transmitter control makes pin mean transmission ended; both may combine
// [RQ12] two commands set or reset the request-to-send state
// [RQ13] pin is nand of latch bit and request-to-send; software sets latch
// [RQ14] flow control leaves latch alone; disabling returns pin to latch
// [RQ15] parity field 11 selects multidrop mode
// [RQ16] multidrop frames carry tag bit from mode one bit 2
// [RQ17] disabled multidrop receiver keeps only address-tagged characters
// [RQ18] enabled receiver keeps all; tag stored in parity error status bit
// [RQ19] framing, overrun, break reported whatever receiver enable state
// [RQ20] reset clears control registers to zero
// [RQ21] software changes modes only while channel and counter are idle
// [RQ22] mode pointer advances per access, saturates at two, resets to one
// [RQ23] pointer commands 1 and b, low nibble enables receiver and transmitter
// [RQ24] timeout-off command restores normal counter start and stop
`timescale 1ns/1ps
`include "ufm_map.svh"
module ufm_top (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic ct_tick_in,
  input wire logic rx_char_in,
  input wire ufm_pkg::ufm_rx_char_type rx_char_data_in,
  input wire logic rx_start_in,
  input wire logic rx_queue_full_in,
  input wire logic rx_ready_in,
  input wire ufm_pkg::ufm_rx_char_type rx_top_in,
  input wire logic tx_char_end_in,
  input wire logic tx_empty_in,
  input wire logic tx_ready_in,
  input wire logic clear_to_send_input_n_in,
  output logic rx_push_out,
  output ufm_pkg::ufm_rx_char_type rx_push_data_out,
  output logic rx_enable_out,
  output logic tx_enable_out,
  output logic tx_allow_out,
  output logic tx_multidrop_out,
  output logic tx_tag_out,
  output logic request_to_send_output_n_out,
  output logic irq_out
);
  // ******************************************************************
  // reset release and pin synchroniser
  // ******************************************************************
  logic rst_meta_reg;
  logic rst_n_reg;
  logic cts_meta_reg;
  logic cts_n_reg;
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      cts_meta_reg <= 1'b1;
      cts_n_reg <= 1'b1;
    end
    else
    begin
      cts_meta_reg <= clear_to_send_input_n_in;
      cts_n_reg <= cts_meta_reg;
    end
  end

  // ******************************************************************
  // register port decode
  // ******************************************************************
  logic [7:0] mr0_reg;
  logic [7:0] mr1_reg;
  logic [7:0] mr2_reg;
  logic [1:0] ptr_reg;
  logic [1:0] ptr_next;
  logic [7:0] imr_reg;
  logic [15:0] preset_reg;
  logic [15:0] count_reg;
  logic [1:0] opr_reg;
  logic rx_en_reg;
  logic tx_en_reg;
  logic tmo_reg;
  logic ready_reg;
  logic room_reg;
  logic hold_reg;
  logic [7:0] rdata_reg;
  ufm_pkg::ufm_ct_state_type ct_reg;
  ufm_pkg::ufm_ct_state_type ct_next;
  wire mode_acc = (wr_in | rd_in) && (addr_in == `UFM_OFS_MODE);
  wire cmd_wr = wr_in && (addr_in == `UFM_OFS_CMD);
  wire [3:0] cmd = wdata_in[7:4];
  wire start_cmd = rd_in && (addr_in == `UFM_OFS_OPSET);
  wire stop_cmd = rd_in && (addr_in == `UFM_OFS_OPCLR);
  wire ptr_one = cmd_wr && (cmd == `UFM_CMD_PTR_ONE);
  wire ptr_zero = cmd_wr && (cmd == `UFM_CMD_PTR_ZERO);
  wire tmo_on = cmd_wr && (cmd == `UFM_CMD_TMO_ON);
  wire tmo_off = cmd_wr && (cmd == `UFM_CMD_TMO_OFF);
  wire rts_on = cmd_wr && (cmd == `UFM_CMD_RTS_ON);
  wire rts_off = cmd_wr && (cmd == `UFM_CMD_RTS_OFF);
  wire opset_wr = wr_in && (addr_in == `UFM_OFS_OPSET);
  wire opclr_wr = wr_in && (addr_in == `UFM_OFS_OPCLR);

  // ******************************************************************
  // mode pointer
  // ******************************************************************
  // a command in the same cycle as an access wins: it names the next target
  assign ptr_next = ptr_one ? 2'h1 : // [RQ23]
                    ptr_zero ? 2'h0 : // [RQ23]
                    (mode_acc && ptr_reg != `UFM_PTR_LAST) ? ptr_reg + 2'h1 : // [RQ22]
                    ptr_reg;

  // ******************************************************************
  // multidrop receive filter
  // ******************************************************************
  wire multidrop = mr1_reg[`UFM_MR1_PAR_HI:`UFM_MR1_PAR_LO] == `UFM_PAR_MULTIDROP; // [RQ15]
  // the tag travels in the parity error position of the pushed status [RQ18]
  wire keep_char = rx_en_reg | (multidrop & rx_char_data_in.tag); // [RQ17] [RQ18]
  wire push = rx_char_in & keep_char;
  // error flags are passed untouched in every mode [RQ19]
  wire ufm_pkg::ufm_rx_char_type push_data = rx_char_data_in;

  // ******************************************************************
  // counter / timer sequencing
  // ******************************************************************
  wire terminal = ct_tick_in && (ct_reg == ufm_pkg::UFM_CT_RUN) && (count_reg == 16'h0000);
  wire ready_set = terminal;
  wire ready_clr = (tmo_reg & push) | tmo_on | (stop_cmd & ~tmo_reg); // [RQ4] [RQ5]
  always_comb
  begin
    ct_next = ct_reg;
    case (ct_reg)
      ufm_pkg::UFM_CT_IDLE:
      begin
        if (!tmo_reg && start_cmd)
          ct_next = ufm_pkg::UFM_CT_LOAD;
      end
      ufm_pkg::UFM_CT_LOAD:
      begin
        if (ct_tick_in)
          ct_next = ufm_pkg::UFM_CT_RUN;
      end
      ufm_pkg::UFM_CT_RUN:
      begin
        // in timeout mode the count ends and waits for the next character
        if (terminal && tmo_reg)
          ct_next = ufm_pkg::UFM_CT_IDLE; // [RQ2]
        else if (terminal)
          ct_next = ufm_pkg::UFM_CT_LOAD;
      end
      default:
        ct_next = ufm_pkg::UFM_CT_IDLE;
    endcase
    if (tmo_reg && push)
      ct_next = ufm_pkg::UFM_CT_LOAD; // [RQ1]
    if (tmo_on)
      ct_next = ufm_pkg::UFM_CT_IDLE; // [RQ5]
    else if (!tmo_reg && stop_cmd)
      ct_next = ufm_pkg::UFM_CT_IDLE; // [RQ24]
  end
  wire [15:0] count_next =
    (ct_reg == ufm_pkg::UFM_CT_LOAD && ct_tick_in) ? preset_reg : // [RQ1]
    (ct_reg == ufm_pkg::UFM_CT_RUN && ct_tick_in && !terminal) ? count_reg - 16'h0001 :
    count_reg;

  // ******************************************************************
  // flow control and output pin
  // ******************************************************************
  // room drops when any start bit is seen with the queue full
  wire room_next = rx_queue_full_in ? (room_reg & ~rx_start_in) : 1'b1; // [RQ9]
  wire rx_rts_ok = mr1_reg[`UFM_MR1_RX_RTS] ? room_reg : 1'b1; // [RQ10] [RQ14]
  // transmitter control raises the pin once the last byte has left
  wire tx_rts_ok = mr2_reg[`UFM_MR2_TX_RTS] ? ~tx_empty_in : 1'b1; // [RQ11]
  wire pin_level = ~(opr_reg[0] & rx_rts_ok & tx_rts_ok); // [RQ13]
  wire [1:0] opr_next = (opr_reg | (opset_wr ? wdata_in[1:0] : 2'h0) | {1'b0, rts_on}) &
                        ~(opclr_wr ? wdata_in[1:0] : 2'h0) &
                        ~{1'b0, rts_off}; // [RQ12]
  // the enable is sampled only between characters so one never gets cut
  wire hold_next = (tx_char_end_in | tx_empty_in) ?
                   (mr2_reg[`UFM_MR2_CTS_EN] & cts_n_reg) : hold_reg; // [RQ7] [RQ8]

  // ******************************************************************
  // read data
  // ******************************************************************
  wire [7:0] interrupt_status_register = {4'h0, ready_reg, 1'b0, rx_ready_in, 1'b0}; // [RQ6]
  wire [7:0] mode_rd = (ptr_reg == 2'h0) ? mr0_reg :
                       (ptr_reg == 2'h1) ? mr1_reg : mr2_reg;
  wire [7:0] status_rd = {rx_top_in.brk, rx_top_in.framing, rx_top_in.tag, // [RQ18]
                          rx_top_in.overrun, tx_empty_in, tx_ready_in,
                          rx_queue_full_in, rx_ready_in};
  wire [7:0] rd_mux = (addr_in == `UFM_OFS_MODE) ? mode_rd :
                      (addr_in == `UFM_OFS_STATUS) ? status_rd :
                      (addr_in == `UFM_OFS_ISR) ? interrupt_status_register :
                      (addr_in == `UFM_OFS_CTU) ? count_reg[15:8] :
                      (addr_in == `UFM_OFS_CTL) ? count_reg[7:0] :
                      (addr_in == `UFM_OFS_INPORT) ? {7'h00, cts_n_reg} :
                      8'h00;

  // ******************************************************************
  // control registers
  // ******************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      mr0_reg <= `UFM_BYTE_RESET; // [RQ20]
      mr1_reg <= `UFM_BYTE_RESET; // [RQ20]
      mr2_reg <= `UFM_BYTE_RESET; // [RQ20]
      imr_reg <= `UFM_BYTE_RESET; // [RQ20]
      ptr_reg <= `UFM_PTR_RESET; // [RQ22]
      preset_reg <= `UFM_WORD_RESET;
      opr_reg <= 2'h0;
      rx_en_reg <= 1'b0;
      tx_en_reg <= 1'b0;
      tmo_reg <= 1'b0;
    end
    else
    begin
      ptr_reg <= ptr_next;
      opr_reg <= opr_next;
      if (wr_in && addr_in == `UFM_OFS_MODE && ptr_reg == 2'h0)
        mr0_reg <= wdata_in;
      if (wr_in && addr_in == `UFM_OFS_MODE && ptr_reg == 2'h1)
        mr1_reg <= wdata_in;
      if (wr_in && addr_in == `UFM_OFS_MODE && ptr_reg == `UFM_PTR_LAST)
        mr2_reg <= wdata_in;
      if (wr_in && addr_in == `UFM_OFS_ISR)
        imr_reg <= wdata_in;
      if (wr_in && addr_in == `UFM_OFS_CTU)
        preset_reg[15:8] <= wdata_in;
      if (wr_in && addr_in == `UFM_OFS_CTL)
        preset_reg[7:0] <= wdata_in;
      if (cmd_wr && wdata_in[1:0] == `UFM_EN_ON)
        rx_en_reg <= 1'b1; // [RQ23]
      if (cmd_wr && wdata_in[1:0] == `UFM_EN_OFF)
        rx_en_reg <= 1'b0; // [RQ23]
      if (cmd_wr && wdata_in[3:2] == `UFM_EN_ON)
        tx_en_reg <= 1'b1; // [RQ23]
      if (cmd_wr && wdata_in[3:2] == `UFM_EN_OFF)
        tx_en_reg <= 1'b0; // [RQ23]
      if (tmo_on)
        tmo_reg <= 1'b1; // [RQ5]
      if (tmo_off)
        tmo_reg <= 1'b0; // [RQ24]
    end
  end

  // ******************************************************************
  // counter, flags and outputs
  // ******************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      ct_reg <= ufm_pkg::UFM_CT_IDLE;
      count_reg <= `UFM_WORD_RESET;
      ready_reg <= 1'b0;
      room_reg <= 1'b1;
      hold_reg <= 1'b0;
      rdata_reg <= `UFM_BYTE_RESET;
      rx_push_out <= 1'b0;
      rx_push_data_out <= '0;
      request_to_send_output_n_out <= 1'b1;
      irq_out <= 1'b0;
    end
    else
    begin
      ct_reg <= ct_next;
      count_reg <= count_next;
      // a terminal count in the clearing cycle is kept
      ready_reg <= ready_set | (ready_reg & ~ready_clr); // [RQ2] [RQ4]
      room_reg <= room_next;
      hold_reg <= hold_next;
      rdata_reg <= rd_in ? rd_mux : rdata_reg;
      rx_push_out <= push; // [RQ17]
      rx_push_data_out <= push_data;
      request_to_send_output_n_out <= pin_level; // [RQ13]
      irq_out <= |(interrupt_status_register & imr_reg); // [RQ3]
    end
  end

  assign rdata_out = rdata_reg;
  assign rx_enable_out = rx_en_reg;
  assign tx_enable_out = tx_en_reg;
  assign tx_allow_out = tx_en_reg & ~hold_reg; // [RQ7] [RQ8]
  assign tx_multidrop_out = multidrop; // [RQ16]
  assign tx_tag_out = mr1_reg[`UFM_MR1_TAG]; // [RQ16]
endmodule

// [verif/testbench.sv]
// self-checking testbench for the flow, multidrop and timeout block
`timescale 1ns/1ps
module testbench;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic ct_tick_in = 1'b0;
  logic tx_empty_in = 1'b0;
  logic rx_ready_in = 1'b0;
  logic tx_char_end_in = 1'b0;
  ufm_pkg::ufm_rx_char_type rx_top_in = 12'h000;
  logic rx_char_in, rx_start_in, rx_queue_full_in, clear_to_send_input_n_in;
  logic [7:0] rdata_out;
  logic rx_push_out, rx_enable_out, tx_enable_out, tx_allow_out, tx_multidrop_out;
  logic tx_tag_out, request_to_send_output_n_out, irq_out;
  ufm_pkg::ufm_rx_char_type rx_char_data_in, rx_push_data_out, last;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int pushes = 0;
  ufm_top i_dut (.mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .ct_tick_in, .rx_char_in, .rx_char_data_in, .rx_start_in, .rx_queue_full_in,
    .rx_ready_in, .rx_top_in, .tx_char_end_in, .tx_empty_in,
    .tx_ready_in(1'b1), .clear_to_send_input_n_in, .rx_push_out, .rx_push_data_out,
    .rx_enable_out, .tx_enable_out, .tx_allow_out, .tx_multidrop_out, .tx_tag_out,
    .request_to_send_output_n_out, .irq_out);
  ufm_remote_model i_rem (.mclk_in, .rx_char_out(rx_char_in),
    .rx_char_data_out(rx_char_data_in), .rx_start_out(rx_start_in),
    .rx_queue_full_out(rx_queue_full_in), .cts_n_out(clear_to_send_input_n_in));
  // ************
  // bus tasks
  // ************
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    ct_tick_in <= ~ct_tick_in;
    if (rx_push_out === 1'b1)
      pushes <= pushes + 1;
    if (rx_push_out === 1'b1)
      last <= rx_push_data_out;
    // whole run needs about 840 cycles
    if (cyc == 5000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    @(posedge mclk_in);
    chk(name, rdata_out, exp);
  endtask
  // pointer to one, then mode one and mode two in turn
  task automatic mset(input logic [7:0] m1, input logic [7:0] m2);
    wr(4'h2, 8'h10);
    wr(4'h0, m1);
    wr(4'h0, m2);
  endtask
  task automatic snd(input logic [7:0] d, input logic tg, input logic ok, input string name);
    int p;
    p = pushes;
    i_rem.send(d, tg);
    wt(3);
    chk(name, 8'(pushes - p), {7'h0, ok});
    if (ok)
    begin
      chk(name, last.data, d);
      chk(name, {4'h0, last.tag, last.framing, last.brk, last.overrun}, {4'h0, tg, 3'b100});
    end
  endtask
  task automatic pin(input logic exp, input string name);
    chk(name, {7'h0, request_to_send_output_n_out}, {7'h0, exp});
  endtask
  // ************
  // tests
  // ************
  initial
  begin
    wt(16);
    @(posedge mclk_in);
    rst_n_in <= 1'b1;
    wt(3);
    chk("reset outputs",
      {4'h0, request_to_send_output_n_out, irq_out, rx_enable_out, tx_enable_out}, 8'h08);
    rd(4'h0, 8'h00, "mode one");
    wr(4'h0, 8'h10);
    rd(4'h0, 8'h10, "mode two held");
    wr(4'h2, 8'hb0);
    rd(4'h0, 8'h00, "mode zero");
    rd(4'h0, 8'h00, "mode one");
    rd(4'h0, 8'h10, "mode two");
    mset(8'h9c, 8'h10);
    wt(2);
    chk("multidrop", {6'h0, tx_multidrop_out, tx_tag_out}, 8'h03);
    $display("test mode pointer done");
    snd(8'h5a, 1'b0, 1'b0, "data tag dropped");
    snd(8'ha5, 1'b1, 1'b1, "address tag kept");
    wr(4'h2, 8'h01);
    snd(8'h3c, 1'b0, 1'b1, "enabled keeps all");
    $display("test multidrop done");
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h20);
    wr(4'h5, 8'h08);
    wr(4'h2, 8'ha0);
    wt(120);
    rd(4'h5, 8'h00, "counter held");
    snd(8'h11, 1'b0, 1'b1, "push");
    wt(120);
    rd(4'h5, 8'h08, "timeout flag");
    chk("irq on", {7'h0, irq_out}, 8'h01);
    snd(8'h22, 1'b0, 1'b1, "push");
    rd(4'h5, 8'h00, "flag withdrawn");
    chk("irq off", {7'h0, irq_out}, 8'h00);
    wr(4'h5, 8'h00);
    wt(120);
    rd(4'h5, 8'h08, "timeout flag");
    chk("irq masked", {7'h0, irq_out}, 8'h00);
    wr(4'h2, 8'ha0);
    rd(4'h5, 8'h00, "flag cleared");
    @(posedge mclk_in);
    rx_ready_in <= 1'b1;
    rd(4'h5, 8'h02, "other source");
    rx_ready_in <= 1'b0;
    wr(4'h2, 8'hc0);
    snd(8'h33, 1'b0, 1'b1, "push");
    wt(120);
    rd(4'h5, 8'h00, "normal counter");
    rd(4'he, 8'h00, "start read");
    wt(120);
    rd(4'h5, 8'h08, "normal count");
    // a terminal count may coincide with the first stop, so stop twice
    rd(4'hf, 8'h00, "stop read");
    rd(4'hf, 8'h00, "stop read");
    rd(4'h5, 8'h00, "stop clears");
    $display("test timeout done");
    wr(4'h2, 8'h82);
    wt(3);
    pin(1'b0, "rts set");
    i_rem.flow(1'b1);
    wt(4);
    pin(1'b1, "rts full");
    i_rem.flow(1'b0);
    wt(4);
    pin(1'b0, "rts room");
    wr(4'h2, 8'h90);
    wt(3);
    pin(1'b1, "rts reset");
    wr(4'h2, 8'h80);
    mset(8'h1c, 8'h30);
    i_rem.flow(1'b1);
    wt(4);
    pin(1'b0, "latch only");
    i_rem.flow(1'b0);
    @(posedge mclk_in);
    tx_empty_in <= 1'b1;
    wt(3);
    pin(1'b1, "tx ended");
    wr(4'h2, 8'h04);
    wt(6);
    chk("cts low", {7'h0, tx_allow_out}, 8'h01);
    i_rem.cts(1'b1);
    wt(6);
    chk("cts high", {7'h0, tx_allow_out}, 8'h00);
    wr(4'h2, 8'h08);
    mset(8'h1c, 8'h20);
    wr(4'h2, 8'h04);
    wt(6);
    chk("cts ignored", {7'h0, tx_allow_out}, 8'h01);
    rd(4'hd, 8'h01, "cts pin");
    @(posedge mclk_in);
    tx_empty_in <= 1'b0;
    wr(4'h2, 8'h08);
    mset(8'h1c, 8'h30);
    wr(4'h2, 8'h04);
    wt(3);
    chk("cts mid char", {7'h0, tx_allow_out}, 8'h01);
    @(posedge mclk_in);
    tx_char_end_in <= 1'b1;
    @(posedge mclk_in);
    tx_char_end_in <= 1'b0;
    wt(2);
    chk("cts char end", {7'h0, tx_allow_out}, 8'h00);
    @(posedge mclk_in);
    rx_top_in <= 12'h00a;
    rd(4'h1, 8'ha4, "status tag");
    $display("test flow control done");
    test_done();
  end
endmodule
bind ufm_top ufm_top_checker i_chk (.mclk_in, .rst_n_in, .wr_in, .ct_tick_in, .rx_char_in,
  .rx_char_data_in, .rx_ready_in, .rx_push_out, .rx_push_data_out, .rx_enable_out,
  .tx_enable_out, .tx_allow_out, .tx_multidrop_out, .tx_tag_out, .irq_out);

// [verif/ufm_remote_model.sv]
// remote transceiver model: characters, start bits and clear-to-send level
`timescale 1ns/1ps
module ufm_remote_model (
  input wire logic mclk_in,
  output logic rx_char_out,
  output ufm_pkg::ufm_rx_char_type rx_char_data_out,
  output logic rx_start_out,
  output logic rx_queue_full_out,
  output logic cts_n_out
);
  // ************
  // line events
  // ************
  initial
  begin
    rx_char_out = 1'b0;
    rx_char_data_out = 12'h000;
    rx_start_out = 1'b0;
    rx_queue_full_out = 1'b0;
    cts_n_out = 1'b0;
  end
  // each frame: start bit, then data with its address tag and framing status
  task automatic send(input logic [7:0] d, input logic tg);
    @(posedge mclk_in);
    rx_start_out <= 1'b1;
    @(posedge mclk_in);
    rx_start_out <= 1'b0;
    rx_char_out <= 1'b1;
    rx_char_data_out <= {d, tg, 1'b1, 1'b0, 1'b0};
    @(posedge mclk_in);
    rx_char_out <= 1'b0;
    // stale data is inverted so nothing can lean on a held value
    rx_char_data_out <= ~rx_char_data_out;
  endtask
  task automatic flow(input logic full);
    @(posedge mclk_in);
    rx_queue_full_out <= full;
    rx_start_out <= 1'b1;
    @(posedge mclk_in);
    rx_start_out <= 1'b0;
  endtask
  // our receiver's request-to-send wire, seen at the block as clear-to-send
  task automatic cts(input logic n);
    @(posedge mclk_in);
    cts_n_out <= n;
  endtask
endmodule

// [verif/ufm_top_checker.sv]
// port assertions for the flow, multidrop and timeout block
`timescale 1ns/1ps
module ufm_top_checker (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wr_in,
  input wire logic ct_tick_in,
  input wire logic rx_char_in,
  input wire ufm_pkg::ufm_rx_char_type rx_char_data_in,
  input wire logic rx_ready_in,
  input wire logic rx_push_out,
  input wire ufm_pkg::ufm_rx_char_type rx_push_data_out,
  input wire logic rx_enable_out,
  input wire logic tx_enable_out,
  input wire logic tx_allow_out,
  input wire logic tx_multidrop_out,
  input wire logic tx_tag_out,
  input wire logic irq_out
);
  // ************
  // relations
  // ************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_push_kept: assert property (rx_char_in && rx_enable_out |=> rx_push_out)
    else $error("enabled receiver lost a character");
  chk_drop_data: assert property (rx_char_in && !rx_enable_out
    && !(tx_multidrop_out && rx_char_data_in.tag) |=> !rx_push_out)
    else $error("disabled receiver kept a character");
  chk_wake_addr: assert property (rx_char_in && tx_multidrop_out
    && rx_char_data_in.tag |=> rx_push_out) else $error("address character lost");
  chk_push_copy: assert property (rx_push_out |->
    rx_push_data_out == $past(rx_char_data_in)) else $error("pushed status differs");
  chk_push_cause: assert property (rx_push_out |-> $past(rx_char_in))
    else $error("push without a character");
  // mode outputs move only after a register write
  chk_mode_hold: assert property (!$past(wr_in) && !$past(wr_in, 2)
    |-> $stable({tx_multidrop_out, tx_tag_out})) else $error("mode changed alone");
  chk_enable_hold: assert property (!$past(wr_in) && !$past(wr_in, 2)
    |-> $stable({rx_enable_out, tx_enable_out})) else $error("enable changed alone");
  chk_allow_en: assert property (tx_allow_out |-> tx_enable_out)
    else $error("transmitter allowed while disabled");
  chk_irq_cause: assert property ($rose(irq_out) |-> $past(ct_tick_in, 2)
    || $past(wr_in) || $past(wr_in, 2) || $past(rx_ready_in) || $past(rx_ready_in, 2))
    else $error("interrupt without cause");
  cover property (rx_push_out && rx_push_data_out.tag);
  cover property ($rose(irq_out));
  cover property ($fell(tx_allow_out));
endmodule
